// ===== inc/rbpe_pkg.sv
// Constants and types of the registered buffer with parity error reporting.
// Assumes one 100 MHz clock and a synchronous, active-high reset.
package rbpe_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int unsigned DATA_W   = 25;       // Data inputs, 1:1 width
  localparam int unsigned FAN_W    = 14;       // Data inputs used in 1:2 mode
  localparam int unsigned OUT_W    = 2 * FAN_W; // Registered output pins

  // ----------------------------------------------------------------------
  // Parity and error timing
  // ----------------------------------------------------------------------
  localparam logic        PAR_BAD     = 1'b1;  // Even parity: a set sum is an error
  localparam logic [1:0]  HOLD_CYCLES = 2'h2;  // Least low time of the error flag
  localparam logic [1:0]  HOLD_LOAD   = HOLD_CYCLES - 2'h1;
  localparam logic [1:0]  HOLD_ZERO   = 2'h0;
  localparam logic [OUT_W-1:0] OUT_RST = '0;

  // ----------------------------------------------------------------------
  // Configuration straps and decoded mode
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic pair_half_select;  // Low: first of a pair, high: second
    logic fanout_select;     // Low: 25-bit 1:1, high: 14-bit 1:2
  } rbpe_cfg_t;

  typedef enum logic [2:0] {
    RBPE_SINGLE = 3'b001,
    RBPE_PAIR_A = 3'b010,
    RBPE_PAIR_B = 3'b100
  } rbpe_mode_t;

endpackage : rbpe_pkg

// ===== verilog/rbpe_core.sv
// Registered command/address buffer with parity check and error flag.
// Assumes the controller meets setup/hold to clk_i and the straps stay static.
`timescale 1ns/1ps
`default_nettype none

module rbpe_core
  import rbpe_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  input  wire rbpe_cfg_t         cfg_i,
  input  wire logic [DATA_W-1:0] data_i,
  input  wire logic              dcs_n_i,
  input  wire logic              csr_n_i,
  input  wire logic              parity_in_i,
  output logic [OUT_W-1:0]       registered_outputs_o,
  output logic                   partial_parity_out_o,
  output logic                   parity_error_n_o,
  output logic                   parity_error_oe_o
);

  // ----------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------
  function automatic rbpe_mode_t mode_of(input rbpe_cfg_t c);
    if (!c.fanout_select) begin
      mode_of = RBPE_SINGLE;
    end else if (!c.pair_half_select) begin
      mode_of = RBPE_PAIR_A;
    end else begin
      mode_of = RBPE_PAIR_B;
    end
  endfunction : mode_of

  function automatic logic [OUT_W-1:0] fan_out(input logic [DATA_W-1:0] d,
                                                input rbpe_cfg_t c);
    if (c.fanout_select) begin
      fan_out = {d[FAN_W-1:0], d[FAN_W-1:0]};
    end else begin
      fan_out = {{(OUT_W-DATA_W){1'b0}}, d};
    end
  endfunction : fan_out

  rbpe_mode_t mode;
  assign mode = mode_of(cfg_i);

  // ----------------------------------------------------------------------
  // Data capture and parity pipeline
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] data_q;
  logic [DATA_W-1:0] next_data_q;
  logic [OUT_W-1:0]  next_outputs;
  logic              next_ppo;
  logic              err_stage;
  logic              next_err_stage;
  logic              check_bad;

  // Parity follows its data by one cycle, so it meets data_q, not data_i
  assign check_bad = ((^data_q) ^ parity_in_i) == PAR_BAD;

  // Outputs freeze when both selects are high; parity keeps being checked
  always_comb begin
    next_data_q    = data_i;
    next_outputs   = registered_outputs_o;
    next_ppo       = (^data_q) ^ parity_in_i;
    next_err_stage = check_bad;
    if (!dcs_n_i || !csr_n_i) begin
      next_outputs = fan_out(data_i, cfg_i);
    end
    if (sys_rst_i) begin
      next_data_q    = '0;
      next_outputs   = OUT_RST;
      next_ppo       = 1'b0;
      next_err_stage = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    data_q               <= next_data_q;
    registered_outputs_o <= next_outputs;
    partial_parity_out_o <= next_ppo;
    err_stage            <= next_err_stage;
  end

  // ----------------------------------------------------------------------
  // Error flag with minimum low time
  // ----------------------------------------------------------------------
  logic       err_fresh;
  logic       err;
  logic       next_err;
  logic [1:0] hold_cnt;
  logic [1:0] next_hold_cnt;

  // The pair's first half reports one edge earlier than the other modes
  always_comb begin
    unique case (mode)
      RBPE_PAIR_A: err_fresh = check_bad;
      RBPE_SINGLE: err_fresh = err_stage;
      RBPE_PAIR_B: err_fresh = err_stage;
    endcase
  end

  // A new error restarts the hold, so a burst keeps the flag low throughout
  always_comb begin
    next_err      = err_fresh || (err && hold_cnt != HOLD_ZERO);
    next_hold_cnt = HOLD_ZERO;
    if (err_fresh) begin
      next_hold_cnt = HOLD_LOAD;
    end else if (hold_cnt != HOLD_ZERO) begin
      next_hold_cnt = hold_cnt - 2'h1;
    end
    if (sys_rst_i) begin
      next_err      = 1'b0;
      next_hold_cnt = HOLD_ZERO;
    end
  end

  // Open drain: the pin level is always low, only the enable moves
  always_ff @(posedge clk_i) begin
    err               <= next_err;
    hold_cnt          <= next_hold_cnt;
    parity_error_oe_o <= next_err;
    parity_error_n_o  <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  logic past_rst;
  always_ff @(posedge clk_i) begin
    past_rst <= sys_rst_i;
  end

  single_latency_a : assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (mode == RBPE_SINGLE && check_bad) |=> ##1 parity_error_oe_o)
    else $error("single mode error not flagged two edges after data");

  single_quiet_a : assert property (@(posedge clk_i) disable iff (sys_rst_i || past_rst)
    (mode == RBPE_SINGLE && !$past(check_bad, 2) && !$past(parity_error_oe_o) &&
     $stable(mode)) |-> !parity_error_oe_o)
    else $error("single mode error raised without a bad parity");

  pair_a_latency_a : assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (mode == RBPE_PAIR_A && check_bad) |=> parity_error_oe_o)
    else $error("pair A error not flagged one edge after data");

  err_hold_a : assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(parity_error_oe_o) |=> parity_error_oe_o)
    else $error("error flag released before two cycles");

  // A reset cut the flag short on the edge before, so skip that one edge
  err_release_a : assert property (@(posedge clk_i) disable iff (sys_rst_i || past_rst)
    $fell(parity_error_oe_o) |-> $past(hold_cnt) == HOLD_ZERO && !$past(err_fresh))
    else $error("error flag released while hold pending");

  rst_err_clear_a : assert property (@(posedge clk_i)
    sys_rst_i |=> !parity_error_oe_o && hold_cnt == HOLD_ZERO)
    else $error("reset did not clear the error flag");

  rst_out_low_a : assert property (@(posedge clk_i)
    sys_rst_i |=> registered_outputs_o == OUT_RST && !partial_parity_out_o)
    else $error("reset did not force outputs low");

  pin_low_a : assert property (@(posedge clk_i) disable iff (sys_rst_i)
    parity_error_oe_o |-> !parity_error_n_o)
    else $error("open drain pin driven high");

  // Both selects high: the capture path must leave the outputs alone
  out_freeze_a : assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (dcs_n_i && csr_n_i) |=> $stable(registered_outputs_o))
    else $error("outputs moved while both selects high");

  // Partial parity carries the checked sum of the word one edge earlier
  ppo_sum_a : assert property (@(posedge clk_i) disable iff (sys_rst_i)
    1'b1 |=> partial_parity_out_o == $past((^data_q) ^ parity_in_i))
    else $error("partial parity does not match the checked word");

  // A fresh error while the flag is low must keep it low another edge
  err_extend_a : assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (parity_error_oe_o && err_fresh) |=> parity_error_oe_o)
    else $error("error flag dropped despite a new error");

  // The hold counter never leaves its loaded range
  hold_range_a : assert property (@(posedge clk_i) disable iff (sys_rst_i)
    hold_cnt <= HOLD_LOAD)
    else $error("hold counter out of range");

  // ----------------------------------------------------------------------
  // Cover properties
  // ----------------------------------------------------------------------
  // Freeze lasting two edges, the case most likely to hide a stale output
  freeze_c : cover property (@(posedge clk_i) disable iff (sys_rst_i)
    (dcs_n_i && csr_n_i) ##1 (dcs_n_i && csr_n_i));

  single_err_c : cover property (@(posedge clk_i) disable iff (sys_rst_i)
    mode == RBPE_SINGLE ##0 check_bad ##2 parity_error_oe_o);

  pair_a_err_c : cover property (@(posedge clk_i) disable iff (sys_rst_i)
    mode == RBPE_PAIR_A ##0 check_bad ##1 parity_error_oe_o);

  rst_during_err_c : cover property (@(posedge clk_i)
    parity_error_oe_o ##1 sys_rst_i);

  burst_hold_c : cover property (@(posedge clk_i) disable iff (sys_rst_i)
    parity_error_oe_o [*4]);

endmodule : rbpe_core

`default_nettype wire

// ===== sim/rbpe_ctrl_model.sv
// Controller model: drives data and late parity into the buffer.
// Assumes the bench changes send/dat/bad just after a falling clock edge.
`timescale 1ns/1ps
`default_nettype none

module rbpe_ctrl_model
  import rbpe_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              send_i,
  input  wire logic              bad_i,
  input  wire logic [DATA_W-1:0] dat_i,
  output logic [DATA_W-1:0]      data_o,
  output var logic               parity_o
);
  logic par_q = 1'b0;

  // Idle bus stays low so a freshly released buffer sees no false error
  assign data_o = send_i ? dat_i : '0;

  // Parity trails its data by one cycle; bad_i flips it to force an error
  always @(posedge clk_i) par_q <= (^data_o) ^ bad_i;
  initial parity_o = 1'b0;
  always @(negedge clk_i) parity_o <= par_q;
endmodule : rbpe_ctrl_model
`default_nettype wire

// ===== sim/rbpe_core_tb_top.sv
// Bench for the parity-checking buffer: each mode, error timing and reset.
// Assumes the controller model stands in front of the block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; \
  $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end

module rbpe_core_tb_top;
  import rbpe_pkg::*;
  logic              clk_i, sys_rst_i, send, bad, par_w, partial_parity_out, parity_error_n_n, oe;
  logic              dcs_n, csr_n;
  logic [DATA_W-1:0] dat, data_w;
  logic [OUT_W-1:0]  q;
  rbpe_cfg_t         cfg;
  int                n_mismatch, n_tests;

  rbpe_ctrl_model i_rbpe_ctrl_model (.clk_i(clk_i), .send_i(send), .bad_i(bad),
    .dat_i(dat), .data_o(data_w), .parity_o(par_w));
  // Selects driven by the bench so the freeze path is reached
  rbpe_core i_rbpe_core (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cfg_i(cfg),
    .data_i(data_w), .dcs_n_i(dcs_n), .csr_n_i(csr_n), .parity_in_i(par_w),
    .registered_outputs_o(q), .partial_parity_out_o(partial_parity_out),
    .parity_error_n_o(parity_error_n_n), .parity_error_oe_o(oe));

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic stop_test;
    $display("Mismatches %0d, checks %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test

  // Straps may only change while reset is held
  task automatic do_reset(input rbpe_cfg_t c);
    sys_rst_i = 1'b1;
    cfg       = c;
    repeat (2) @(negedge clk_i);
    sys_rst_i = 1'b0;
  endtask : do_reset

  // One word, then idle; the flag must rise at lat and hold two cycles
  task automatic xfer(input logic [DATA_W-1:0] d, input logic b, input int lat);
    logic [OUT_W-1:0] f;
    f    = cfg.fanout_select ? {d[13:0], d[13:0]} : {3'h0, d};
    send = 1'b1;
    dat  = d;
    bad  = b;
    @(negedge clk_i);
    `CHK(q, f)
    send = 1'b0;
    bad  = 1'b0;
    for (int k = 1; k < 7; k++) begin
      @(negedge clk_i);
      if (k == 1) `CHK(partial_parity_out, b)
      `CHK(oe, b && (k == lat || k == lat + 1))
      `CHK(parity_error_n_n, 1'b0)
    end
  endtask : xfer

  // Reset in the middle of a flagged error clears flag and outputs at once
  task automatic reset_mid_error;
    do_reset('{1'b0, 1'b0});
    send = 1'b1;
    dat  = 25'h1AB_CDEF;
    bad  = 1'b1;
    @(negedge clk_i);
    bad  = 1'b0;
    repeat (2) @(negedge clk_i);
    `CHK(oe, 1'b1)
    sys_rst_i = 1'b1;
    send      = 1'b0;
    @(negedge clk_i);
    `CHK(oe, 1'b0)
    `CHK({q, partial_parity_out}, 29'h0)
    sys_rst_i = 1'b0;
  endtask : reset_mid_error

  // Both selects high: outputs keep the last word, parity still checked
  task automatic freeze_hold;
    send = 1'b1;
    dat  = 25'h0F0_F0F0;
    @(negedge clk_i);
    `CHK(q, {3'h0, 25'h0F0_F0F0})
    dcs_n = 1'b1;
    csr_n = 1'b1;
    dat   = 25'h10F_0F0F;
    @(negedge clk_i);
    `CHK(q, {3'h0, 25'h0F0_F0F0})
    send  = 1'b0;
    dcs_n = 1'b0;
    repeat (3) @(negedge clk_i);
    `CHK(oe, 1'b0)
  endtask : freeze_hold

  // ----------------------------------------------------------------------
  // Clock and main sequence
  // ----------------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    {sys_rst_i, send, bad, dat, n_mismatch, n_tests} = '0;
    dcs_n     = 1'b0;
    csr_n     = 1'b1;
    sys_rst_i = 1'b1;
    cfg       = '{1'b0, 1'b0};
    repeat (12) @(negedge clk_i);
    do_reset('{1'b0, 1'b0});
    xfer(25'h155_5555, 1'b0, 2);
    xfer(25'h0AA_AAAA, 1'b1, 2);
    do_reset('{1'b0, 1'b1});
    xfer(25'h000_3A5C, 1'b1, 1);
    do_reset('{1'b1, 1'b1});
    xfer(25'h000_1FFF, 1'b1, 2);
    reset_mid_error();
    freeze_hold();
    stop_test();
  end
endmodule : rbpe_core_tb_top
`default_nettype wire
